// >>> core/reset_and_power_mode_control.sv
/*
  Reset merging, power-on stretch counter and idle/stop mode control,
  with the power control, chip configuration and status registers.
  Assumes a same-clock register master with one-cycle strobes, a CPU
  that gates itself on cpu_clk_en and qualifies interrupts by priority
  before raising irq_wake.
*/
`timescale 1ns/10ps
// What this block does
// [RULE_01] idle gates cpu clock, peripherals keep running; adc_off still switches the converter off in idle
// [RULE_02] stop keeps ram and registers intact
// [RULE_03] stop exit reloads registers, ram kept
// [RULE_04] five sources drive the internal reset
// [RULE_05] power-on sets hold, clears counter
// [RULE_06] counter steps each clock once oscillator stable
// [RULE_07] overflow at 2048 releases hold
// [RULE_08] reset pin sampled at fourth phase
// [RULE_09] pin held high two instruction cycles
// [RULE_10] chip config bit 0 high disables low-voltage reset
// [RULE_11] watchdog overflow resets in run and idle
// [RULE_12] idle and stop switch converter off
// [RULE_13] idle ends on interrupt or reset
// [RULE_14] stop ends only on external reset
// [RULE_15] stop wins when both bits set
// [RULE_16] stop refused while watchdog enabled
// [RULE_17] stop halts the oscillator
// [RULE_18] ports keep latched data while sleeping
// [RULE_19] pin request synchronised before merging
module reset_and_power_mode_control (
  // clock and power-on reset
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  // reset and wake sources
  input  wire logic       reset_pin,
  input  wire logic       low_volt_det,
  input  wire logic       osc_stable,
  input  wire logic       wdt_overflow,
  input  wire logic       wdt_enabled,
  input  wire logic       isp_busy,
  input  wire logic       irq_wake,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // reset and power controls
  output logic            internal_reset_hold,
  output logic            sys_reset,
  output logic            cpu_clk_en,
  output logic            osc_run,
  output logic            adc_off,
  output logic            port_hold,
  output logic            baud_double
);

  localparam int unsigned CW = rst_pwr_pkg::POR_CNT_W;

  logic                   rst_meta_q;
  logic                   rst_n_q;
  logic [2:0]             pin_meta_q;
  logic [2:0]             pin_sync_q;
  logic                   pin_s;
  logic                   lvd_s;
  logic                   osc_s;
  logic                   hold_q;
  logic                   hold_d;
  logic [CW-1:0]          por_cnt_q;
  logic [CW-1:0]          por_cnt_d;
  rst_pwr_pkg::pwr_mode_t mode_q;
  rst_pwr_pkg::pwr_mode_t mode_d;
  logic [7:0]             pctl_q;
  logic [7:0]             pctl_d;
  logic [7:0]             chipcfg_q;
  logic [7:0]             chipcfg_d;
  logic                   lvd_req;
  logic                   rst_src;
  logic                   int_reset_d;
  logic                   int_reset_q;
  logic                   cpu_clk_en_q;
  logic                   osc_run_q;
  logic                   adc_off_q;
  logic                   port_hold_q;
  logic [7:0]             rdata_q;
  logic [7:0]             pctl_wr;
  logic                   stop_ok;

  phase_if ph ();

  // register read decode
  function automatic logic [7:0] read_mux(input logic [7:0] addr);
    logic [7:0] st;
    st = 8'h00;
    st[rst_pwr_pkg::STAT_HOLD_BIT] = hold_q;
    st[rst_pwr_pkg::STAT_IDLE_BIT] = (mode_q == rst_pwr_pkg::MODE_IDLE);
    st[rst_pwr_pkg::STAT_STOP_BIT] = (mode_q == rst_pwr_pkg::MODE_STOP);
    case (addr)
      rst_pwr_pkg::PCTL_ADDR:    read_mux = pctl_q;
      rst_pwr_pkg::CHIPCFG_ADDR: read_mux = chipcfg_q;
      rst_pwr_pkg::STATUS_ADDR:  read_mux = st;
      default:                   read_mux = 8'h00;
    endcase
  endfunction

  // release of the power-on reset through two flops
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // pins come from outside the clock domain, two flops each
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pin_meta_q <= 3'h0;
      pin_sync_q <= 3'h0;
    end else begin
      pin_meta_q <= {osc_stable, low_volt_det, reset_pin};
      pin_sync_q <= pin_meta_q; // RULE_19
    end
  end

  assign pin_s = pin_sync_q[0];
  assign lvd_s = pin_sync_q[1];
  assign osc_s = pin_sync_q[2];

  // phase sampler runs only while the oscillator does
  assign ph.run       = osc_run_q && osc_s;
  assign ph.pin_level = pin_s; // RULE_19

  instr_phase_sampler u_sampler (
    .ref_clk (ref_clk),
    .rst_n   (rst_n_q),
    .ph      (ph.gen)
  );

  // merge of reset sources; a stopped part sees only the pin, level
  // sensitive, since no instruction cycle runs to sample it
  assign lvd_req = lvd_s &&
                   !chipcfg_q[rst_pwr_pkg::CHIPCFG_LVOFF_BIT]; // RULE_10
  always_comb begin
    if (mode_q == rst_pwr_pkg::MODE_STOP) begin
      rst_src = pin_s; // RULE_14
    end else begin
      rst_src = ph.ext_req || lvd_req || // RULE_04
                wdt_overflow || isp_busy; // RULE_11
    end
  end

  // stretch counter; waking from stop restarts it like power-on
  always_comb begin
    hold_d    = hold_q;
    por_cnt_d = por_cnt_q;
    if (mode_q == rst_pwr_pkg::MODE_STOP && pin_s) begin
      hold_d    = 1'b1; // RULE_03
      por_cnt_d = '0;
    end else if (hold_q && osc_s) begin
      if (por_cnt_q == rst_pwr_pkg::POR_LAST) begin
        hold_d    = 1'b0; // RULE_07
        por_cnt_d = '0;
      end else begin
        por_cnt_d = CW'(por_cnt_q + 1'b1); // RULE_06
      end
    end
  end

  assign int_reset_d = hold_d || rst_src; // RULE_04

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      hold_q    <= 1'b1; // RULE_05
      por_cnt_q <= '0;
    end else begin
      hold_q    <= hold_d;
      por_cnt_q <= por_cnt_d;
    end
  end

  // mode and register next state; writes land only while running
  // since a halted core cannot issue them
  always_comb begin
    mode_d    = mode_q;
    pctl_d    = pctl_q;
    chipcfg_d = chipcfg_q;
    pctl_wr   = reg_wdata & rst_pwr_pkg::PCTL_WMASK;
    stop_ok   = pctl_wr[rst_pwr_pkg::PCTL_STOP_BIT] && !wdt_enabled;
    if (int_reset_d) begin
      mode_d    = rst_pwr_pkg::MODE_RUN; // RULE_03 RULE_13
      pctl_d    = rst_pwr_pkg::PCTL_RST;
      chipcfg_d = rst_pwr_pkg::CHIPCFG_RST;
    end else begin
      case (mode_q)
        rst_pwr_pkg::MODE_RUN: begin
          if (reg_wr && reg_addr == rst_pwr_pkg::CHIPCFG_ADDR) begin
            chipcfg_d = reg_wdata;
          end
          if (reg_wr && reg_addr == rst_pwr_pkg::PCTL_ADDR) begin
            if (stop_ok) begin
              mode_d = rst_pwr_pkg::MODE_STOP; // RULE_15
            end else begin
              pctl_wr[rst_pwr_pkg::PCTL_STOP_BIT] = 1'b0; // RULE_16
              if (pctl_wr[rst_pwr_pkg::PCTL_IDLE_BIT]) begin
                mode_d = rst_pwr_pkg::MODE_IDLE;
              end
            end
            pctl_d = pctl_wr;
          end
        end
        rst_pwr_pkg::MODE_IDLE: begin
          if (irq_wake) begin
            mode_d = rst_pwr_pkg::MODE_RUN; // RULE_13
            pctl_d[rst_pwr_pkg::PCTL_IDLE_BIT] = 1'b0;
          end
        end
        rst_pwr_pkg::MODE_STOP: begin
          mode_d = rst_pwr_pkg::MODE_STOP; // RULE_02 RULE_14
        end
        default: begin
          mode_d = rst_pwr_pkg::MODE_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mode_q    <= rst_pwr_pkg::MODE_RUN;
      pctl_q    <= rst_pwr_pkg::PCTL_RST;
      chipcfg_q <= rst_pwr_pkg::CHIPCFG_RST;
    end else begin
      mode_q    <= mode_d;
      pctl_q    <= pctl_d;
      chipcfg_q <= chipcfg_d;
    end
  end

  // control outputs from next state so they line up with mode_q
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      int_reset_q  <= 1'b1;
      cpu_clk_en_q <= 1'b0;
      osc_run_q    <= 1'b1;
      adc_off_q    <= 1'b0;
      port_hold_q  <= 1'b0;
    end else begin
      int_reset_q  <= int_reset_d;
      cpu_clk_en_q <= !int_reset_d &&
                      mode_d == rst_pwr_pkg::MODE_RUN; // RULE_01
      osc_run_q    <= mode_d != rst_pwr_pkg::MODE_STOP; // RULE_17
      adc_off_q    <= mode_d != rst_pwr_pkg::MODE_RUN; // RULE_12
      port_hold_q  <= mode_d != rst_pwr_pkg::MODE_RUN; // RULE_18
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= reg_rd ? read_mux(reg_addr) : 8'h00;
    end
  end

  assign reg_rdata           = rdata_q;
  assign internal_reset_hold = hold_q;
  assign sys_reset           = int_reset_q;
  assign cpu_clk_en          = cpu_clk_en_q;
  assign osc_run             = osc_run_q;
  assign adc_off             = adc_off_q;
  assign port_hold           = port_hold_q;
  assign baud_double         = pctl_q[rst_pwr_pkg::PCTL_BAUD_BIT];

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n_q);

  sequence por_overflow_s;
    hold_q && osc_s && por_cnt_q == rst_pwr_pkg::POR_LAST;
  endsequence
  sequence stop_request_s;
    mode_q == rst_pwr_pkg::MODE_RUN && !int_reset_d && reg_wr &&
    reg_addr == rst_pwr_pkg::PCTL_ADDR &&
    reg_wdata[rst_pwr_pkg::PCTL_STOP_BIT];
  endsequence

  a_idle_cpu_gated: assert property ( // RULE_01
    mode_q == rst_pwr_pkg::MODE_IDLE |-> !cpu_clk_en_q && adc_off_q)
    else $error("cpu clock or converter running in idle");

  a_stop_osc_halt: assert property ( // RULE_17
    mode_q == rst_pwr_pkg::MODE_STOP |-> !osc_run_q && port_hold_q)
    else $error("oscillator running in stop");

  a_stop_regs_kept: assert property ( // RULE_02
    mode_q == rst_pwr_pkg::MODE_STOP && !pin_s |=>
      $stable(pctl_q) && $stable(chipcfg_q) &&
      mode_q == rst_pwr_pkg::MODE_STOP)
    else $error("stop left or registers changed without reset pin");

  a_stop_wake_reload: assert property ( // RULE_03
    mode_q == rst_pwr_pkg::MODE_STOP && pin_s |=>
      hold_q && sys_reset && pctl_q == rst_pwr_pkg::PCTL_RST)
    else $error("stop exit did not reload registers");

  a_stop_priority: assert property ( // RULE_15
    stop_request_s ##0 !wdt_enabled |=>
      mode_q == rst_pwr_pkg::MODE_STOP)
    else $error("stop request not honoured");

  a_stop_refused: assert property ( // RULE_16
    stop_request_s ##0 wdt_enabled |=>
      mode_q != rst_pwr_pkg::MODE_STOP &&
      !pctl_q[rst_pwr_pkg::PCTL_STOP_BIT])
    else $error("stop entered with watchdog enabled");

  a_por_counter: assert property ( // RULE_05
    $rose(rst_n_q) |-> hold_q && por_cnt_q == '0 && sys_reset)
    else $error("power-on did not set hold and clear counter");

  a_count_step: assert property ( // RULE_06
    hold_q && osc_s && por_cnt_q != rst_pwr_pkg::POR_LAST &&
    mode_q != rst_pwr_pkg::MODE_STOP |=>
      por_cnt_q == CW'($past(por_cnt_q) + 1'b1))
    else $error("stretch counter did not step");

  a_hold_release: assert property ( // RULE_07
    por_overflow_s ##1 !rst_src [*1] |-> !hold_q)
    else $error("hold not released at overflow");

  a_lvd_gate: assert property ( // RULE_10
    lvd_s && !chipcfg_q[rst_pwr_pkg::CHIPCFG_LVOFF_BIT] &&
    mode_q != rst_pwr_pkg::MODE_STOP |=> sys_reset)
    else $error("low-voltage reset not applied");

  a_wdt_reset: assert property ( // RULE_11
    wdt_overflow && mode_q != rst_pwr_pkg::MODE_STOP |=>
      sys_reset && mode_q == rst_pwr_pkg::MODE_RUN)
    else $error("watchdog overflow did not reset");

  a_idle_wake: assert property ( // RULE_13
    mode_q == rst_pwr_pkg::MODE_IDLE && irq_wake && !int_reset_d |=>
      mode_q == rst_pwr_pkg::MODE_RUN &&
      !pctl_q[rst_pwr_pkg::PCTL_IDLE_BIT] && cpu_clk_en_q)
    else $error("interrupt did not end idle");

endmodule

// >>> core/rst_pwr_pkg.sv
/*
  Shared constants and types for the reset and power mode controller:
  register offsets, field positions, reset values, counts and modes.
  Assumes an 8-bit register space addressed by plain offsets.
*/
package rst_pwr_pkg;

  // register offsets
  localparam logic [7:0] PCTL_ADDR    = 8'h87;
  localparam logic [7:0] CHIPCFG_ADDR = 8'hBF;
  localparam logic [7:0] STATUS_ADDR  = 8'hBE;

  // power control fields
  localparam int unsigned PCTL_IDLE_BIT = 0;
  localparam int unsigned PCTL_STOP_BIT = 1;
  localparam int unsigned PCTL_FLG0_BIT = 2;
  localparam int unsigned PCTL_FLG1_BIT = 3;
  localparam int unsigned PCTL_BAUD_BIT = 7;
  localparam logic [7:0]  PCTL_RST      = 8'h00;
  localparam logic [7:0]  PCTL_WMASK    = 8'h8F;

  // chip configuration fields
  localparam int unsigned CHIPCFG_LVOFF_BIT = 0;
  localparam logic [7:0]  CHIPCFG_RST       = 8'h00;

  // status fields
  localparam int unsigned STAT_HOLD_BIT = 0;
  localparam int unsigned STAT_IDLE_BIT = 1;
  localparam int unsigned STAT_STOP_BIT = 2;

  // timing
  localparam int unsigned CLK_PERIOD_NS  = 50;
  localparam int unsigned POR_COUNT      = 2048;
  localparam int unsigned POR_CNT_W      = 11;
  localparam logic [POR_CNT_W-1:0] POR_LAST = POR_CNT_W'(POR_COUNT - 1);
  localparam int unsigned CLKS_PER_INSTR = 12;
  localparam logic [3:0]  PHASE_LAST     = 4'(CLKS_PER_INSTR - 1);
  localparam int unsigned EXT_SAMPLES    = 2;

  // operating modes, one-hot
  typedef enum logic [2:0] {
    MODE_RUN  = 3'b001,
    MODE_IDLE = 3'b010,
    MODE_STOP = 3'b100
  } pwr_mode_t;

endpackage

// >>> core/phase_if.sv
/*
  Carrier between the controller and its instruction phase sampler.
  Assumes both ends share ref_clk.
*/
`timescale 1ns/10ps
interface phase_if;
  logic run;
  logic pin_level;
  logic c4;
  logic ext_req;

  modport gen (input run, input pin_level, output c4, output ext_req);
  modport ctl (output run, output pin_level, input c4, input ext_req);
endinterface

// >>> core/instr_phase_sampler.sv
/*
  Instruction cycle phase counter and external reset pin sampler.
  Assumes pin_level is already synchronised to ref_clk and that run
  is low while the oscillator is halted.
*/
`timescale 1ns/10ps
module instr_phase_sampler (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // controller side
  phase_if.gen     ph
);

  logic [3:0] phase_q;
  logic       c4_q;
  logic [1:0] hi_q;
  logic       req_q;
  logic       c4_now;
  logic [1:0] hi_next;

  // last clock of the fourth phase of the instruction cycle
  assign c4_now  = ph.run && (phase_q == rst_pwr_pkg::PHASE_LAST);
  // saturate so a long hold does not wrap back below the threshold
  assign hi_next = (hi_q == 2'(rst_pwr_pkg::EXT_SAMPLES)) ? hi_q
                                                           : 2'(hi_q + 2'h1);

  // phase counter, parked while the oscillator is stopped
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= 4'h0;
      c4_q    <= 1'b0;
    end else begin
      c4_q <= c4_now;
      if (!ph.run || phase_q == rst_pwr_pkg::PHASE_LAST) begin
        phase_q <= 4'h0;
      end else begin
        phase_q <= 4'(phase_q + 4'h1);
      end
    end
  end

  // pin sampled once per instruction cycle, consecutive highs counted
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hi_q  <= 2'h0;
      req_q <= 1'b0;
    end else if (!ph.run) begin
      hi_q  <= 2'h0;
      req_q <= 1'b0;
    end else if (c4_now) begin // RULE_08
      if (ph.pin_level) begin
        hi_q  <= hi_next;
        req_q <= (hi_next == 2'(rst_pwr_pkg::EXT_SAMPLES));
      end else begin
        hi_q  <= 2'h0;
        req_q <= 1'b0;
      end
    end
  end

  assign ph.c4      = c4_q;
  assign ph.ext_req = req_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_c4_spacing: assert property ( // RULE_08
    c4_q |=> !c4_q [*8] ##1 !c4_q [*3])
    else $error("sample strobe closer than one instruction cycle");

  a_low_sample_drop: assert property ( // RULE_08
    c4_now && !ph.pin_level |=> !req_q)
    else $error("reset request kept after a low pin sample");

endmodule

// >>> tb/reset_source_model.sv
/*
  Far-side model: external reset source and crystal oscillator.
  Assumes ref_clk keeps running; the pin has a pull-down, and the
  oscillator reports stable only some clocks after osc_run returns.
*/
`timescale 1ns/10ps
module reset_source_model (
  // clock
  input  wire logic        ref_clk,
  // bench command and controller enable
  input  wire logic        pulse_go,
  input  wire logic [15:0] pulse_clks,
  input  wire logic        osc_run,
  // far-side lines
  output logic             reset_pin,
  output logic             osc_stable
);
  logic [15:0] left_q = 16'h0000;
  logic [3:0]  warm_q = 4'h0;

  // pin held high for the commanded clocks, pulled low otherwise
  always @(posedge ref_clk) begin
    if (pulse_go) begin
      left_q <= pulse_clks;
    end else if (left_q != 16'h0000) begin
      left_q <= left_q - 16'h0001;
    end
  end
  assign reset_pin = (left_q != 16'h0000);

  // warm-up delay so the stretch never starts on a halted oscillator
  always @(posedge ref_clk) begin
    if (!osc_run) begin
      warm_q <= 4'h0;
    end else if (warm_q != 4'h8) begin
      warm_q <= warm_q + 4'h1;
    end
  end
  assign osc_stable = (warm_q == 4'h8);
endmodule

// >>> tb/testbench.sv
/*
  Self-checking bench for the reset and power mode controller.
  Assumes the far-side model in reset_source_model.sv.
*/
`timescale 1ns/10ps
module testbench;
  logic        ref_clk      = 1'b0;
  logic        nrst         = 1'b0;
  logic        low_volt_det = 1'b0;
  logic        wdt_overflow = 1'b0;
  logic        wdt_enabled  = 1'b0;
  logic        isp_busy     = 1'b0;
  logic        irq_wake     = 1'b0;
  logic [7:0]  reg_addr     = 8'h00;
  logic [7:0]  reg_wdata    = 8'h00;
  logic        reg_wr       = 1'b0;
  logic        reg_rd       = 1'b0;
  logic        pulse_go     = 1'b0;
  logic [15:0] pulse_clks   = 16'h0000;
  logic        rd_seen      = 1'b0;
  logic [7:0]  reg_rdata;
  logic        hold, sys_reset, cpu_clk_en, osc_run, adc_off;
  logic        port_hold, baud_double, reset_pin, osc_stable;
  logic [7:0]  outs;
  logic [7:0]  exp_q[$];
  logic [7:0]  v;
  int          mismatches = 0;
  int          n_compared = 0;
  int          cycles     = 0;
  int          seed       = 89;
  int          n;

  // 50 ns period
  always #25 ref_clk = ~ref_clk;

  // all mode outputs packed so one compare covers them together
  assign outs = {1'b0, baud_double, port_hold, adc_off, osc_run,
                 cpu_clk_en, sys_reset, hold};

  reset_and_power_mode_control u_dut (
    .ref_clk(ref_clk), .nrst(nrst), .reset_pin(reset_pin),
    .low_volt_det(low_volt_det), .osc_stable(osc_stable),
    .wdt_overflow(wdt_overflow), .wdt_enabled(wdt_enabled),
    .isp_busy(isp_busy), .irq_wake(irq_wake), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .internal_reset_hold(hold),
    .sys_reset(sys_reset), .cpu_clk_en(cpu_clk_en), .osc_run(osc_run),
    .adc_off(adc_off), .port_hold(port_hold), .baud_double(baud_double)
  );

  reset_source_model u_far (
    .ref_clk(ref_clk), .pulse_go(pulse_go), .pulse_clks(pulse_clks),
    .osc_run(osc_run), .reset_pin(reset_pin), .osc_stable(osc_stable)
  );

  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // read data stand one cycle after the strobe; oldest note first
  always @(posedge ref_clk) begin
    rd_seen <= reg_rd;
    cycles <= cycles + 1;
    if (rd_seen && exp_q.size() > 0) begin
      chk(reg_rdata, exp_q.pop_front(), "read data");
    end
    if (cycles == 40000) begin
      mismatches++;
      $display("MISMATCH at %0t: run too long", $time);
      wrap_up();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask

  // bounded wait for the internal reset to reach a level; looks only
  // after the edge has settled, so a one-cycle reset is still seen
  task automatic wait_rst(input logic lvl, input int max);
    n = 0;
    #1;
    while (sys_reset !== lvl && n < max) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
  endtask

  // one-cycle pulse on the interrupt wake line
  task automatic wake();
    @(posedge ref_clk);
    irq_wake <= 1'b1;
    @(posedge ref_clk);
    irq_wake <= 1'b0;
    step(2);
  endtask

  initial begin
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    #1;
    chk(outs, 8'h0B, "in reset");
    wait_rst(1'b0, 3000);
    chk(8'(n >= 2048 && n <= 2080), 8'h01, "stretch");
    chk(outs, 8'h0C, "run");
    rd(8'h87, 8'h00);
    rd(8'hBF, 8'h00);
    rd(8'hBE, 8'h00);
    rd(8'h33, 8'h00);
    $display("power-on done");
    for (int i = 0; i < 4; i++) begin
      v = 8'($random(seed));
      wr(8'hBF, v);
      rd(8'hBF, v);
    end
    wr(8'h87, 8'hFC);
    rd(8'h87, 8'h8C);
    step(2);
    chk(outs, 8'h4C, "rate doubler");
    wr(8'hBF, 8'h01);
    wr(8'h87, 8'h00);
    @(posedge ref_clk);
    low_volt_det <= 1'b1;
    step(8);
    chk(outs, 8'h0C, "low voltage masked");
    wr(8'hBF, 8'h00);
    wait_rst(1'b1, 8);
    chk(outs[1], 1'b1, "low voltage reset");
    @(posedge ref_clk);
    low_volt_det <= 1'b0;
    wait_rst(1'b0, 3000);
    rd(8'hBF, 8'h00);
    @(posedge ref_clk);
    isp_busy <= 1'b1;
    wait_rst(1'b1, 6);
    chk(outs[1], 1'b1, "programming reset");
    @(posedge ref_clk);
    isp_busy <= 1'b0;
    wait_rst(1'b0, 3000);
    $display("reset sources done");
    wr(8'h87, 8'h05);
    step(2);
    chk(outs, 8'h38, "idle");
    rd(8'hBE, 8'h02);
    wr(8'hBF, 8'h01);
    rd(8'hBF, 8'h00);
    repeat (1 + ($unsigned($random(seed)) % 16)) @(posedge ref_clk);
    wake();
    chk(outs, 8'h0C, "idle wake");
    rd(8'h87, 8'h04);
    wr(8'h87, 8'h01);
    step(2);
    @(posedge ref_clk);
    wdt_overflow <= 1'b1;
    @(posedge ref_clk);
    wdt_overflow <= 1'b0;
    wait_rst(1'b1, 4);
    chk(outs[1], 1'b1, "watchdog in idle");
    wait_rst(1'b0, 3000);
    rd(8'h87, 8'h00);
    $display("idle done");
    wdt_enabled <= 1'b1;
    wr(8'h87, 8'h03);
    step(2);
    chk(outs, 8'h38, "stop refused");
    wake();
    @(posedge ref_clk);
    wdt_enabled <= 1'b0;
    wr(8'hBF, 8'h01);
    wr(8'h87, 8'h07);
    step(2);
    chk(outs, 8'h30, "stop");
    rd(8'hBE, 8'h04);
    rd(8'hBF, 8'h01);
    wake();
    @(posedge ref_clk);
    wdt_overflow <= 1'b1;
    isp_busy <= 1'b1;
    @(posedge ref_clk);
    wdt_overflow <= 1'b0;
    isp_busy <= 1'b0;
    step(4);
    chk(outs, 8'h30, "stop holds");
    @(posedge ref_clk);
    pulse_clks <= 16'h001E;
    pulse_go <= 1'b1;
    @(posedge ref_clk);
    pulse_go <= 1'b0;
    wait_rst(1'b1, 40);
    chk(outs[1], 1'b1, "stop exit");
    wait_rst(1'b0, 3000);
    chk(outs, 8'h0C, "after stop");
    rd(8'hBF, 8'h00);
    rd(8'h87, 8'h00);
    $display("stop done");
    @(posedge ref_clk);
    pulse_clks <= 16'h000C;
    pulse_go <= 1'b1;
    @(posedge ref_clk);
    pulse_go <= 1'b0;
    step(30);
    chk(outs, 8'h0C, "short pin pulse");
    @(posedge ref_clk);
    pulse_clks <= 16'h001E;
    pulse_go <= 1'b1;
    @(posedge ref_clk);
    pulse_go <= 1'b0;
    wait_rst(1'b1, 40);
    chk(8'(n >= 14 && n < 40), 8'h01, "pin reset");
    wait_rst(1'b0, 3000);
    chk(outs, 8'h0C, "pin release");
    $display("pin reset done");
    step(4);
    wrap_up();
  end
endmodule
